//--- verilog/artmr_pkg.sv
// Purpose: Shared constants and carriers for the 16-bit auto-reload timer
// Assumes: 32-bit AXI4-Lite register slave, word aligned offsets
// Notes:   16-bit registers sit in bits 15:0, upper bits read as zero
package artmr_pkg;
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_IRQ_EN    = 8'h04;
   localparam logic [7:0]  OFF_FLAGS     = 8'h08;
   localparam logic [7:0]  OFF_COUNT     = 8'h0c;
   localparam logic [7:0]  OFF_RELOAD    = 8'h10;
   localparam logic [7:0]  OFF_COMPARE   = 8'h14;
   localparam logic [7:0]  OFF_MASK      = 8'h18;
   localparam logic [7:0]  OFF_CAPTURE   = 8'h1c;
   localparam logic [7:0]  OFF_PINS      = 8'h20;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [15:0] CNT_ALL_ONES  = 16'hffff;
   localparam logic [15:0] CNT_ZERO      = 16'h0000;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET    = 16'hffff;
   localparam logic [4:0]  IRQ_EN_RESET  = 5'h00;
   localparam logic [3:0]  PSC_DIV4_LAST = 4'h3;
   localparam logic [3:0]  PSC_DIV16_LAST = 4'hf;
   // Irq enable bit positions
   localparam int          IEN_A         = 0;
   localparam int          IEN_B         = 1;
   localparam int          IEN_OVF       = 2;
   localparam int          IEN_CMP       = 3;
   localparam int          IEN_ZERO      = 4;

   typedef enum logic [1:0] {
      PSC_OFF   = 2'b00,
      PSC_DIV1  = 2'b01,
      PSC_DIV4  = 2'b10,
      PSC_DIV16 = 2'b11
   } psc_sel_t;

   typedef enum logic [1:0] {
      RST_SOFT  = 2'b00,
      RST_IN_A  = 2'b01,
      RST_IN_B  = 2'b10,
      RST_NONE  = 2'b11
   } restart_src_t;

   typedef struct packed {
      logic [3:0]   rsvd;
      restart_src_t restart_source_sel;
      logic         input_b_edge_sel;
      logic         input_a_edge_sel;
      logic         pwm_polarity;
      logic         pwm_out_style;
      logic         pwm_out_enable;
      logic         overflow_out_mode;
      logic         run_reset_ctl;
      logic         reload_en;
      psc_sel_t     prescale_sel;
   } ctrl_t;

   typedef struct packed {
      logic zero_match_flag;
      logic compare_match_flag;
      logic overflow_flag;
      logic input_b_overrun_flag;
      logic input_b_event_flag;
      logic input_a_overrun_flag;
      logic input_a_event_flag;
   } flags_t;
endpackage

//--- verilog/auto_reload_timer_16bit.sv
// Purpose: 16-bit auto-reload down counter with compare, capture, pwm and overflow pins
// Assumes: ref_clk at 10 MHz, sys_rst synchronous active high, AXI4-Lite registers
// Notes:   Capture inputs are asynchronous and pass three flops before use
// What this block does
// - Counter steps via prescaler dividing by 1, 4, 16.
// - Run bit low stops counter, holds zero.
// - Underflow without reload loads all ones.
// - Reload underflow loads reload value; overflow flag set.
// - Reload mode input event reloads the counter.
// - Masked zero and compare matches set flags.
// - Input B captures always; A only without reload.
// - Without reload, counter free runs during captures.
// - Reload mode: start event reloads, later event captures.
// - Set/reset style: zero drives pulse pin to polarity, compare to its inverse.
// - Toggle style inverts pulse pin at compare.
// - Overflow pin set, released when flag cleared.
// - Toggle overflow mode inverts pin each overflow.
// - Input A restart mode: select 01 with reload.
// - In that mode each A edge reloads, flags.
// - A reload with flag still set marks overrun.
// - Input B edge captures counter, sets B flag.
// - B flag still set: overrun, captures blocked.
// - Simultaneous B capture takes value before A reload.
// - Input A edge select: 0 falling, 1 rising.
// - Prescale select 00 off, 01/10/11 divide 1/4/16.
// - Interrupt is OR of event, overflow and match flags ANDed with enables; overrun flags excluded.
// - High byte staged, committed with low byte write.
`timescale 1ns/1ps
module auto_reload_timer_16bit
   import artmr_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              capture_input_a,
   input  wire logic              capture_input_b,
   output logic                   pulse_pin,
   output logic                   overflow_pin,
   output logic                   timer_irq
);
   ctrl_t             ctrl_q;
   flags_t            flags_q, flags_set, flags_clr;
   logic [4:0]        irq_en_q;
   logic [15:0]       cnt_q, cnt_d, reload_q, compare_q, mask_q, capture_q;
   logic [7:0]        stage_q;
   logic [3:0]        psc_q;
   logic              tick, run_prev_q, run_rise, restart, cnt_upd;
   logic              ovf_evt, zero_hit, cmp_hit, cap_b_ok, cap_a_ok;
   logic [1:0]        s1_q, s2_q, s3_q, rise, fall;
   logic              a_edge, b_edge;
   logic              aw_held_q, w_held_q, wr_fire;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic [15:0]       wr16;
   logic              pulse_q, ovf_pin_q, bvalid_q, rvalid_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q;

   // Input synchronisers; a change counts when stages two and three differ
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= gi == 0 ? capture_input_a : capture_input_b;
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
            end
         end
         assign rise[gi] = s2_q[gi] & ~s3_q[gi];
         assign fall[gi] = ~s2_q[gi] & s3_q[gi];
      end
   endgenerate

   // Edges only count while running
   assign a_edge = ctrl_q.run_reset_ctl &
                   (ctrl_q.input_a_edge_sel ? rise[0] : fall[0]);
   assign b_edge = ctrl_q.run_reset_ctl & (ctrl_q.input_b_edge_sel ? rise[1] : fall[1]);

   // Prescaler
   always_comb begin
      case (ctrl_q.prescale_sel)
         PSC_OFF:   tick = 1'b0;
         PSC_DIV1:  tick = 1'b1;
         PSC_DIV4:  tick = psc_q[1:0] == PSC_DIV4_LAST[1:0];
         PSC_DIV16: tick = psc_q == PSC_DIV16_LAST;
         default:   tick = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !ctrl_q.run_reset_ctl || ctrl_q.prescale_sel == PSC_OFF) begin
         psc_q <= 4'h0;
      end else begin
         psc_q <= psc_q + 4'h1;
      end
   end

   // Counter
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         run_prev_q <= 1'b0;
      end else begin
         run_prev_q <= ctrl_q.run_reset_ctl;
      end
   end
   assign run_rise = ctrl_q.run_reset_ctl & ~run_prev_q;
   always_comb begin
      restart = 1'b0;
      if (ctrl_q.run_reset_ctl && ctrl_q.reload_en) begin
         case (ctrl_q.restart_source_sel)
            RST_IN_A: restart = a_edge;
            RST_IN_B: restart = b_edge;
            RST_SOFT: restart = run_rise;
            RST_NONE: restart = 1'b0;
            default:  restart = 1'b0;
         endcase
      end
   end

   assign ovf_evt = ctrl_q.run_reset_ctl & ~restart & tick & (cnt_q == CNT_ZERO);
   assign cnt_upd = ctrl_q.run_reset_ctl & (tick | restart);
   always_comb begin
      if (!ctrl_q.run_reset_ctl) begin
         cnt_d = CNT_ZERO;
      end else if (restart) begin
         cnt_d = reload_q;
      end else if (ovf_evt) begin
         cnt_d = ctrl_q.reload_en ? reload_q : CNT_ALL_ONES;
      end else if (tick) begin
         cnt_d = cnt_q - 16'h0001;
      end else begin
         cnt_d = cnt_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q <= CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Matches judged on the value the counter moves to
   assign zero_hit = cnt_upd & ((cnt_d & mask_q) == CNT_ZERO);
   assign cmp_hit  = cnt_upd & ((cnt_d & mask_q) == (compare_q & mask_q));

   // Captures
   assign cap_b_ok = b_edge & ~flags_q.input_b_event_flag & ~flags_q.input_b_overrun_flag;
   assign cap_a_ok = a_edge & ~ctrl_q.reload_en & ~flags_q.input_a_event_flag &
                     ~flags_q.input_a_overrun_flag;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         capture_q <= CNT_ZERO;
      end else if (cap_b_ok) begin
         capture_q <= cnt_q;
      end
   end

   // Flags: hardware set wins over a software clear in the same cycle
   always_comb begin
      flags_set                      = '0;
      flags_set.input_a_event_flag   = a_edge;
      flags_set.input_a_overrun_flag = a_edge & flags_q.input_a_event_flag;
      flags_set.input_b_event_flag   = b_edge & ~flags_q.input_b_overrun_flag;
      flags_set.input_b_overrun_flag = b_edge & flags_q.input_b_event_flag;
      flags_set.overflow_flag        = ovf_evt;
      flags_set.compare_match_flag   = cmp_hit;
      flags_set.zero_match_flag      = zero_hit;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~flags_clr) | flags_set;
      end
   end

   // Pulse pin
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pulse_q <= 1'b0;
      end else if (!ctrl_q.pwm_out_enable) begin
         pulse_q <= ctrl_q.pwm_polarity;
      end else if (ctrl_q.pwm_out_style) begin
         if (cmp_hit) begin
            pulse_q <= ~pulse_q;
         end
      end else if (zero_hit) begin
         pulse_q <= ctrl_q.pwm_polarity;
      end else if (cmp_hit) begin
         pulse_q <= ~ctrl_q.pwm_polarity;
      end
   end
   assign pulse_pin = pulse_q;

   // Overflow pin
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ovf_pin_q <= 1'b0;
      end else if (ctrl_q.overflow_out_mode) begin
         if (ovf_evt) begin
            ovf_pin_q <= ~ovf_pin_q;
         end
      end else if (ovf_evt) begin
         ovf_pin_q <= 1'b1;
      end else if (!flags_q.overflow_flag) begin
         ovf_pin_q <= 1'b0;
      end
   end
   assign overflow_pin = ovf_pin_q;

   assign timer_irq = (flags_q.input_a_event_flag & irq_en_q[IEN_A]) |
                      (flags_q.input_b_event_flag & irq_en_q[IEN_B]) |
                      (flags_q.overflow_flag      & irq_en_q[IEN_OVF]) |
                      (flags_q.compare_match_flag & irq_en_q[IEN_CMP]) |
                      (flags_q.zero_match_flag    & irq_en_q[IEN_ZERO]);

   // AXI4-Lite write path: address and data held until both are in
   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready  = ~w_held_q;
   assign wr_fire       = aw_held_q & w_held_q & ~bvalid_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         w_held_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (awaddr_q[ADDR_W-1:2] > OFF_PINS[ADDR_W-1:2] || awaddr_q[1:0] != 2'b00) ?
                     RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   // Word committed with the low byte, high byte from lane or staging
   assign wr16 = {wstrb_q[1] ? wdata_q[15:8] : stage_q, wdata_q[7:0]};

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage_q <= 8'h00;
      end else if (wr_fire && wstrb_q[1]) begin
         stage_q <= wdata_q[15:8];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_q    <= CTRL_RESET;
         compare_q <= COMPARE_RESET;
         mask_q    <= MASK_RESET;
         irq_en_q  <= IRQ_EN_RESET;
      end else if (wr_fire && wstrb_q[0]) begin
         case (awaddr_q)
            OFF_CTRL:    ctrl_q    <= {4'h0, wr16[11:0]};
            OFF_COMPARE: compare_q <= wr16;
            OFF_MASK:    mask_q    <= wr16;
            OFF_IRQ_EN:  irq_en_q  <= wdata_q[4:0];
            default:     ;
         endcase
      end
   end

   // Capture beats a software write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reload_q <= RELOAD_RESET;
      end else if (cap_a_ok) begin
         reload_q <= cnt_q;
      end else if (wr_fire && wstrb_q[0] && awaddr_q == OFF_RELOAD) begin
         reload_q <= wr16;
      end
   end

   assign flags_clr = (wr_fire && wstrb_q[0] && awaddr_q == OFF_FLAGS) ?
                      wdata_q[6:0] : '0;
   // AXI4-Lite read path, one cycle latency
   assign s_axi_arready = ~rvalid_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case (s_axi_araddr)
            OFF_CTRL:    rdata_q <= {16'h0000, ctrl_q};
            OFF_IRQ_EN:  rdata_q <= {27'h0, irq_en_q};
            OFF_FLAGS:   rdata_q <= {25'h0, flags_q};
            OFF_COUNT:   rdata_q <= {16'h0000, cnt_q};
            OFF_RELOAD:  rdata_q <= {16'h0000, reload_q};
            OFF_COMPARE: rdata_q <= {16'h0000, compare_q};
            OFF_MASK:    rdata_q <= {16'h0000, mask_q};
            OFF_CAPTURE: rdata_q <= {16'h0000, capture_q};
            OFF_PINS:    rdata_q <= {29'h0, timer_irq, overflow_pin, pulse_pin};
            default: begin
               rdata_q <= '0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   stop_clear_a: assert property (!ctrl_q.run_reset_ctl |=> cnt_q == CNT_ZERO)
      else $error("counter not cleared while stopped");
   wrap_ones_a: assert property (
      ovf_evt && !ctrl_q.reload_en |=> cnt_q == CNT_ALL_ONES)
      else $error("underflow did not load all ones");
   reload_ovf_a: assert property (ovf_evt && ctrl_q.reload_en
      |=> cnt_q == $past(reload_q) && flags_q.overflow_flag)
      else $error("underflow reload or overflow flag wrong");
   restart_load_a: assert property (restart |=> cnt_q == $past(reload_q))
      else $error("restart did not load reload value");
   zero_flag_a: assert property (zero_hit |=> flags_q.zero_match_flag)
      else $error("zero match flag not set");
   capture_b_a: assert property (cap_b_ok |=> capture_q == $past(cnt_q))
      else $error("capture did not take pre-reload value");
   a_overrun_a: assert property (a_edge && flags_q.input_a_event_flag
      |=> flags_q.input_a_overrun_flag)
      else $error("input a overrun not flagged");
   b_block_a: assert property (b_edge && flags_q.input_b_overrun_flag
      |=> capture_q == $past(capture_q))
      else $error("capture not blocked after overrun");
   ovf_toggle_a: assert property (ovf_evt && ctrl_q.overflow_out_mode
      |=> overflow_pin != $past(overflow_pin))
      else $error("overflow pin did not toggle");
   pwm_off_a: assert property (
      !ctrl_q.pwm_out_enable |=> pulse_pin == $past(ctrl_q.pwm_polarity))
      else $error("pulse pin not at polarity when disabled");
   psc_off_a: assert property (ctrl_q.prescale_sel == PSC_OFF && !restart
      |=> cnt_q == $past(cnt_q) || $past(!ctrl_q.run_reset_ctl))
      else $error("counter moved with prescaler off");

   restart_c: cover property (restart ##1 cnt_upd);
   overflow_c: cover property (ovf_evt && ctrl_q.reload_en);
   b_overrun_c: cover property (b_edge && flags_q.input_b_event_flag);
endmodule

//--- tb/cap_src.sv
// Purpose: Far-side model driving the two capture input pins
// Assumes: Pins change just after a ref_clk edge
// Notes:   Each level is held well past the three-flop synchroniser
`timescale 1ns/1ps
module cap_src (
   input  wire logic ref_clk,
   output logic      pin_a,
   output logic      pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // Both pins move on one edge so a joint event is truly joint
   task automatic drive(input logic a, input logic b);
      @(posedge ref_clk);
      pin_a <= a;
      pin_b <= b;
      repeat (6) @(posedge ref_clk);
   endtask
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the auto-reload timer
// Assumes: ref_clk 100 ns, reset held 16 cycles
// Notes:   Rates judged on read-to-read cycle gaps, so bus latency cancels
`timescale 1ns/1ps
module tb;
   import artmr_pkg::*;
   localparam logic [31:0] F_RUN = 32'h0008, F_REL = 32'h0004, F_OVT = 32'h0010;
   localparam logic [31:0] F_PEN = 32'h0020, F_PTG = 32'h0040, F_POL = 32'h0080;
   localparam logic [31:0] F_EDG = 32'h0300, F_SRA = 32'h0400;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      logic [1:0]  r;
      logic [31:0] q;
   } row_t;
   typedef struct {
      logic [31:0] c;
      logic [15:0] m;
      int          hi;
      int          tg;
   } pwm_t;
   row_t        rows[8] = '{
      '{OFF_RELOAD, 32'h1234, 4'h3, RESP_OKAY, 32'h1234},
      '{OFF_COMPARE, 32'hab00, 4'h2, RESP_OKAY, 32'h0},
      '{OFF_COMPARE, 32'h0055, 4'h1, RESP_OKAY, 32'hab55},
      '{OFF_MASK, 32'hffff00f0, 4'h3, RESP_OKAY, 32'h00f0},
      '{OFF_MASK, 32'h0011, 4'h1, RESP_OKAY, 32'h0011},
      '{OFF_IRQ_EN, 32'h1f, 4'h1, RESP_OKAY, 32'h1f},
      '{8'h24, 32'h1, 4'h1, RESP_SLVERR, 32'h0},
      '{8'h02, 32'h1, 4'h1, RESP_SLVERR, 32'h0}};
   pwm_t        pw[6] = '{'{F_PEN | F_POL, 16'hffff, 48, 16}, '{F_PEN, 16'hffff, 16, 16},
      '{F_PEN | F_PTG, 16'hffff, 32, 8}, '{F_PEN | F_PTG, 16'h0001, 32, 32},
      '{F_POL, 16'hffff, 64, 0}, '{32'h0, 16'hffff, 0, 0}};
   logic [7:0]  rst_a[9] = '{OFF_CTRL, OFF_IRQ_EN, OFF_FLAGS, OFF_COUNT, OFF_RELOAD,
      OFF_COMPARE, OFF_MASK, OFF_CAPTURE, OFF_PINS};
   logic [31:0] rst_q[9] = '{0, 0, 0, 0, 0, 0, 32'hffff, 0, 0};
   int          dv[4] = '{1, 1, 4, 16};
   logic        ref_clk, sys_rst, pin_a, pin_b, pulse_pin, overflow_pin, timer_irq;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
   logic [15:0] v1, dl;
   int          mismatches, checks, cyc, rc, c1, d, hi, tg, ot;

   auto_reload_timer_16bit DUT (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .capture_input_a(pin_a), .capture_input_b(pin_b), .pulse_pin, .overflow_pin,
      .timer_irq);
   cap_src src (.ref_clk(ref_clk), .pin_a(pin_a), .pin_b(pin_b));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;

   function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, hi);
      return v >= lo && v <= hi;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s = 4'h3);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge ref_clk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      rc = cyc;
      s_axi_rready <= 1'b0;
   endtask
   // Window of 64 cycles holds whole periods, so counts are exact
   task automatic meas();
      logic pp;
      logic op;
      hi = 0;
      tg = 0;
      ot = 0;
      @(posedge ref_clk);
      pp = pulse_pin;
      op = overflow_pin;
      repeat (64) begin
         @(posedge ref_clk);
         hi += (pulse_pin === 1'b1);
         tg += (pulse_pin !== pp);
         ot += (overflow_pin !== op);
         pp = pulse_pin;
         op = overflow_pin;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      $display("mismatch at %0t: watchdog", $time);
      wrap_up();
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      mismatches = 0;
      checks = 0;
      sys_rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d, rows[k].s);
         chk(br, rows[k].r, "bresp");
         rd(rows[k].a);
         chk(rv, rows[k].q, "readback");
         chk(rr, rows[k].r, "rresp");
      end
      $display("done registers");
      wr(OFF_MASK, 32'hffff);
      rd(OFF_COUNT);
      chk(rv, 32'h0, "stopped");
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, 32'h0);
         wr(OFF_CTRL, F_RUN | i);
         rd(OFF_COUNT);
         v1 = rv[15:0];
         c1 = rc;
         if (i == 1) chk(v1[15:8], 32'hff, "wrap to ones");
         repeat (60) @(posedge ref_clk);
         rd(OFF_COUNT);
         d = (i == 0) ? 0 : (rc - c1) / dv[i];
         dl = v1 - rv[15:0];
         chk(in_rng(dl, d, d + (i > 1)), 1, "rate");
      end
      rd(OFF_FLAGS);
      chk(rv[4], 1, "ovf flag");
      chk(overflow_pin, 1, "ovf pin set");
      wr(OFF_IRQ_EN, 32'h04, 4'h1);
      chk(timer_irq, 1, "irq on");
      wr(OFF_IRQ_EN, 32'h00, 4'h1);
      chk(timer_irq, 0, "irq masked");
      wr(OFF_FLAGS, 32'h10, 4'h1);
      repeat (3) @(posedge ref_clk);
      chk(overflow_pin, 0, "ovf pin cleared");
      $display("done counter");
      wr(OFF_RELOAD, 32'h7);
      wr(OFF_COMPARE, 32'h2);
      foreach (pw[k]) begin
         wr(OFF_MASK, {16'h0, pw[k].m});
         wr(OFF_CTRL, 32'h0);
         wr(OFF_CTRL, F_RUN | F_REL | F_OVT | 32'h1 | pw[k].c);
         repeat (20) @(posedge ref_clk);
         meas();
         chk(hi, pw[k].hi, "pulse high");
         chk(tg, pw[k].tg, "pulse edges");
         chk(ot, 8, "ovf toggles");
      end
      rd(OFF_FLAGS);
      chk(rv[6:5], 32'h3, "match flags");
      $display("done outputs");
      wr(OFF_RELOAD, 32'h0200);
      wr(OFF_FLAGS, 32'h7f, 4'h1);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, F_RUN | F_REL | F_EDG | F_SRA | 32'h1);
      // Drift first, so a missed restart shows
      repeat (100) @(posedge ref_clk);
      src.drive(1'b1, 1'b0);
      rd(OFF_COUNT);
      chk(in_rng(rv[15:0], 16'h01e0, 16'h0200), 1, "a restart");
      rd(OFF_FLAGS);
      chk(rv[1:0], 32'h1, "a event");
      src.drive(1'b0, 1'b0);
      rd(OFF_FLAGS);
      chk(rv[1:0], 32'h1, "falling a");
      src.drive(1'b1, 1'b0);
      rd(OFF_FLAGS);
      chk(rv[1:0], 32'h3, "a overrun");
      wr(OFF_FLAGS, 32'h03, 4'h1);
      src.drive(1'b1, 1'b1);
      rd(OFF_CAPTURE);
      v1 = rv[15:0];
      chk(in_rng(v1, 16'h0100, 16'h01ff), 1, "b capture");
      src.drive(1'b1, 1'b0);
      src.drive(1'b1, 1'b1);
      rd(OFF_FLAGS);
      chk(rv[3:0], 32'hc, "b overrun");
      rd(OFF_CAPTURE);
      chk(rv[15:0], v1, "b blocked");
      wr(OFF_FLAGS, 32'h0c, 4'h1);
      repeat (300) @(posedge ref_clk);
      src.drive(1'b0, 1'b0);
      src.drive(1'b1, 1'b1);
      rd(OFF_CAPTURE);
      chk(in_rng(rv[15:0], 16'h0001, 16'h00ff), 1, "capture first");
      rd(OFF_COUNT);
      chk(in_rng(rv[15:0], 16'h01e0, 16'h0200), 1, "then reload");
      $display("done restart");
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, F_RUN | 32'h0200 | 32'h1);
      wr(OFF_FLAGS, 32'h7f, 4'h1);
      src.drive(1'b0, 1'b0);
      src.drive(1'b1, 1'b0);
      rd(OFF_RELOAD);
      v1 = rv[15:0];
      chk(in_rng(v1, 16'hff00, 16'hffff), 1, "a into reload");
      rd(OFF_COUNT);
      chk(in_rng(rv[15:0], 16'hff00, v1 - 16'h1), 1, "free run");
      $display("done capture");
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (rst_a[k]) begin
         rd(rst_a[k]);
         chk(rv, rst_q[k], "reset value");
      end
      $display("done reset");
      wrap_up();
   end
endmodule
